// [uart_regs_pkg.sv]
package uart_regs_pkg;
	// Register select codes on the internal data bus
	localparam logic [2:0] SEL_STATUS = 3'h0;
	localparam logic [2:0] SEL_CTRL_PRI = 3'h1;
	localparam logic [2:0] SEL_CTRL_SEC = 3'h2;
	localparam logic [2:0] SEL_DATA = 3'h3;
	localparam logic [2:0] SEL_BAUD = 3'h4;
	// Status bit positions
	localparam int POS_PARITY = 7;
	localparam int POS_NOISE = 6;
	localparam int POS_FRAMING = 5;
	localparam int POS_OVERRUN = 4;
	localparam int POS_RX_IDLE = 3;
	localparam int POS_RX_AVAIL = 2;
	localparam int POS_TX_IDLE = 1;
	localparam int POS_TX_EMPTY = 0;
	// Primary control positions
	localparam int POS_PORT_EN = 7;
	localparam int POS_NINE_BIT = 6;
	localparam int POS_PARITY_EN = 5;
	localparam int POS_PARITY_ODD = 4;
	localparam int POS_TWO_STOP = 3;
	localparam int POS_BREAK = 2;
	localparam int POS_RX_BIT8 = 1;
	localparam int POS_TX_BIT8 = 0;
	// Secondary control positions
	localparam int POS_TX_EN = 7;
	localparam int POS_RX_EN = 6;
	localparam int POS_RX_IRQ_EN = 2;
	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h0b;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// Receive buffer depth
	localparam int RX_DEPTH = 2;
endpackage

// [uart_rx_buffer.sv]
`timescale 1ns/1ps
module uart_rx_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = uart_regs_pkg::RX_DEPTH
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_flush,
	// Fill side
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_data,
	// Drain side
	input wire logic i_pop,
	output logic [WIDTH-1:0] o_data,
	output logic o_empty,
	output logic o_full,
	output logic o_many
);
	// Two entries: the word software sees plus one behind it
	if (DEPTH != 2) begin : g_depth_check
		$error("uart_rx_buffer supports depth two only");
	end

	typedef struct packed {
		logic [1:0] [WIDTH-1:0] word;
		logic [1:0] count;
	} buf_s;

	buf_s st;
	buf_s next_st;

	always_comb begin
		next_st = st;
		if (i_pop && st.count != 2'h0) begin
			next_st.word[0] = st.word[1];
			next_st.count = st.count - 2'h1;
		end
		if (i_push && next_st.count != 2'h2) begin
			next_st.word[next_st.count[0]] = i_data;
			next_st.count = next_st.count + 2'h1;
		end
		if (i_flush)
			next_st.count = 2'h0;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_data = st.word[0];
	assign o_empty = (st.count == 2'h0);
	assign o_full = (st.count == 2'h2);
	assign o_many = (st.count == 2'h2);
endmodule

// [uart_status_and_data_registers.sv]
`timescale 1ns/1ps
// Behaviour
// - Status flags read-only; reset: idle and tx-empty one, others zero.
// - Parity mismatch sets parity flag, bit 7, only with parity enabled.
// - Status read then data access clears parity flag.
// - Noise sets bit 6 with data-available, never for an overrun word.
// - Status read then data access clears noise flag.
// - Bad framing sets bit 5; status read then data access clears it.
// - Buffer overflow sets bit 4 and blocks further transfers meanwhile.
// - Overrun clears only after status read then data access, or on port disable.
// - Receiver idle, bit 3, low from start bit until stop completes.
// - Transfer sets data-available bit 2; interrupt if enabled.
// - Error flags set in same cycle the word enters receive buffer.
// - Data-available clears after status read, data read, buffer empty.
// - Transmitter idle, bit 1, one when empty and nothing sending.
// - Status read with idle set, then data write clears idle.
// - Transmitter idle stays low while character or break is queued.
// - One shared 8-bit data register: write transmits, read receives.
// - Tx-empty sets on shift load or enable; cleared by read-write.
// - Port disable resets flags: idle and empty one, others zero.
module uart_status_and_data_registers (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Internal data bus
	input wire logic [2:0] i_sel,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// Receive engine
	input wire logic i_rx_busy,
	input wire logic i_rx_done,
	input wire logic [8:0] i_rx_word,
	input wire logic i_rx_parity_bad,
	input wire logic i_rx_noise,
	input wire logic i_rx_frame_bad,
	// Transmit engine
	input wire logic i_tx_busy,
	input wire logic i_tx_load,
	output logic o_tx_pending,
	output logic [8:0] o_tx_word,
	// Control outputs
	output logic [7:0] o_ctrl_pri,
	output logic [7:0] o_ctrl_sec,
	output logic [7:0] o_baud_divider,
	output logic o_rx_irq
);
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] armed;
		logic [7:0] ctrl_pri;
		logic [7:0] ctrl_sec;
		logic [7:0] baud;
		logic [8:0] tx_word;
		logic tx_pending;
		logic [7:0] rdata;
		logic rx_irq;
		logic rx_bit8;
	} regs_s;

	regs_s st;
	regs_s next_st;

	logic buf_push;
	logic buf_pop;
	logic buf_flush;
	logic [8:0] buf_data;
	logic buf_empty;
	logic buf_full;
	logic buf_many;

	// Second entry holds the word behind the one software sees
	uart_rx_buffer #(
		.WIDTH(9),
		.DEPTH(uart_regs_pkg::RX_DEPTH)
	) u_rx_buffer (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_flush(buf_flush),
		.i_push(buf_push),
		.i_data(i_rx_word),
		.i_pop(buf_pop),
		.o_data(buf_data),
		.o_empty(buf_empty),
		.o_full(buf_full),
		.o_many(buf_many)
	);

	logic port_en;
	logic rx_en;
	logic tx_en;
	logic stat_rd;
	logic data_rd;
	logic data_wr;
	logic data_acc;
	logic rx_take;
	logic rx_over;

	assign port_en = st.ctrl_pri[uart_regs_pkg::POS_PORT_EN];
	assign rx_en = port_en && st.ctrl_sec[uart_regs_pkg::POS_RX_EN];
	assign tx_en = port_en && st.ctrl_sec[uart_regs_pkg::POS_TX_EN];
	assign stat_rd = i_rd && i_sel == uart_regs_pkg::SEL_STATUS;
	assign data_rd = i_rd && i_sel == uart_regs_pkg::SEL_DATA;
	assign data_wr = i_wr && i_sel == uart_regs_pkg::SEL_DATA;
	assign data_acc = data_rd || data_wr;
	// Overrun blocks the transfer; word is dropped
	assign rx_take = rx_en && i_rx_done && !buf_full
		&& !st.status[uart_regs_pkg::POS_OVERRUN];
	assign rx_over = rx_en && i_rx_done && buf_full;
	assign buf_push = rx_take;
	assign buf_pop = data_rd && !buf_empty;
	assign buf_flush = !rx_en;

	always_comb begin
		next_st = st;
		next_st.rx_irq = 1'b0;
		// Clears from an armed status read, on data access
		if (data_acc) begin
			for (int b = 4; b <= 7; b++) begin
				if (st.armed[b])
					next_st.status[b] = 1'b0;
			end
			next_st.armed[7:4] = 4'h0;
		end
		if (data_rd && st.armed[uart_regs_pkg::POS_RX_AVAIL]) begin
			if (!buf_many)
				next_st.status[uart_regs_pkg::POS_RX_AVAIL] = 1'b0;
			next_st.armed[uart_regs_pkg::POS_RX_AVAIL] = 1'b0;
		end
		if (data_wr) begin
			if (st.armed[uart_regs_pkg::POS_TX_IDLE])
				next_st.status[uart_regs_pkg::POS_TX_IDLE] = 1'b0;
			if (st.armed[uart_regs_pkg::POS_TX_EMPTY])
				next_st.status[uart_regs_pkg::POS_TX_EMPTY] = 1'b0;
			next_st.armed[1:0] = 2'h0;
			next_st.tx_word = {st.ctrl_pri[uart_regs_pkg::POS_TX_BIT8],
				i_wdata};
			next_st.tx_pending = 1'b1;
		end
		// Arm only flags seen set by this read
		if (stat_rd)
			next_st.armed = next_st.armed | st.status;
		// Receive transfer: set wins over any clear above
		if (rx_take) begin
			next_st.status[uart_regs_pkg::POS_RX_AVAIL] = 1'b1;
			next_st.rx_irq = st.ctrl_sec[uart_regs_pkg::POS_RX_IRQ_EN];
			if (i_rx_noise) begin
				next_st.status[uart_regs_pkg::POS_NOISE] = 1'b1;
				next_st.armed[uart_regs_pkg::POS_NOISE] = 1'b0;
			end
			if (i_rx_frame_bad) begin
				next_st.status[uart_regs_pkg::POS_FRAMING] = 1'b1;
				next_st.armed[uart_regs_pkg::POS_FRAMING] = 1'b0;
			end
			if (i_rx_parity_bad
				&& st.ctrl_pri[uart_regs_pkg::POS_PARITY_EN]) begin
				next_st.status[uart_regs_pkg::POS_PARITY] = 1'b1;
				next_st.armed[uart_regs_pkg::POS_PARITY] = 1'b0;
			end
			next_st.armed[uart_regs_pkg::POS_RX_AVAIL] = 1'b0;
		end
		if (rx_over) begin
			next_st.status[uart_regs_pkg::POS_OVERRUN] = 1'b1;
			next_st.armed[uart_regs_pkg::POS_OVERRUN] = 1'b0;
		end
		next_st.status[uart_regs_pkg::POS_RX_IDLE] = !i_rx_busy;
		// Transmit side
		if (i_tx_load && st.tx_pending) begin
			next_st.tx_pending = 1'b0;
			next_st.status[uart_regs_pkg::POS_TX_EMPTY] = 1'b1;
			next_st.armed[uart_regs_pkg::POS_TX_EMPTY] = 1'b0;
		end
		if (i_wr && i_sel == uart_regs_pkg::SEL_CTRL_SEC
			&& i_wdata[uart_regs_pkg::POS_TX_EN]
			&& !st.ctrl_sec[uart_regs_pkg::POS_TX_EN])
			next_st.status[uart_regs_pkg::POS_TX_EMPTY] = 1'b1;
		// Idle needs empty, no queued word, no break
		if (next_st.status[uart_regs_pkg::POS_TX_EMPTY] && !i_tx_busy
			&& !next_st.tx_pending
			&& !st.ctrl_pri[uart_regs_pkg::POS_BREAK]) begin
			if (!st.status[uart_regs_pkg::POS_TX_IDLE])
				next_st.armed[uart_regs_pkg::POS_TX_IDLE] = 1'b0;
			next_st.status[uart_regs_pkg::POS_TX_IDLE] = 1'b1;
		end else if (i_tx_busy || next_st.tx_pending
			|| st.ctrl_pri[uart_regs_pkg::POS_BREAK])
			next_st.status[uart_regs_pkg::POS_TX_IDLE] = 1'b0;
		if (!tx_en)
			next_st.tx_pending = 1'b0;
		// Control writes
		if (i_wr) begin
			case (i_sel)
				uart_regs_pkg::SEL_CTRL_PRI: begin
					// Received ninth bit stays read-only
					next_st.ctrl_pri = {i_wdata[7:2],
						st.ctrl_pri[uart_regs_pkg::POS_RX_BIT8], i_wdata[0]};
				end
				uart_regs_pkg::SEL_CTRL_SEC: begin
					next_st.ctrl_sec = i_wdata;
				end
				uart_regs_pkg::SEL_BAUD: begin
					next_st.baud = i_wdata;
				end
				default: begin
				end
			endcase
		end
		// Ninth bit follows the head word, also after a pop
		next_st.rx_bit8 = buf_data[8];
		next_st.ctrl_pri[uart_regs_pkg::POS_RX_BIT8] = st.rx_bit8;
		// Port disable returns every flag to its idle value
		if (!port_en) begin
			next_st.status = uart_regs_pkg::STATUS_RESET;
			next_st.armed = 8'h00;
			next_st.tx_pending = 1'b0;
			next_st.ctrl_pri[uart_regs_pkg::POS_BREAK] = 1'b0;
			next_st.ctrl_sec[uart_regs_pkg::POS_TX_EN] = 1'b0;
			next_st.ctrl_sec[uart_regs_pkg::POS_RX_EN] = 1'b0;
			next_st.rx_irq = 1'b0;
		end
		// Read data registered; status is read-only
		case (i_sel)
			uart_regs_pkg::SEL_STATUS: next_st.rdata = st.status;
			uart_regs_pkg::SEL_CTRL_PRI: next_st.rdata = {st.ctrl_pri[7:1],
				1'b0};
			uart_regs_pkg::SEL_CTRL_SEC: next_st.rdata = st.ctrl_sec;
			uart_regs_pkg::SEL_DATA: next_st.rdata = buf_data[7:0];
			uart_regs_pkg::SEL_BAUD: next_st.rdata = st.baud;
			default: next_st.rdata = 8'h00;
		endcase
		if (i_wr && i_sel == uart_regs_pkg::SEL_CTRL_PRI
			&& i_wdata[uart_regs_pkg::POS_PORT_EN] && !port_en)
			next_st.status = uart_regs_pkg::STATUS_RESET;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st <= '0;
			st.status <= uart_regs_pkg::STATUS_RESET;
			st.ctrl_pri <= uart_regs_pkg::CTRL_RESET;
			st.ctrl_sec <= uart_regs_pkg::CTRL_RESET;
			st.baud <= uart_regs_pkg::CTRL_RESET;
			st.tx_word <= {1'b0, uart_regs_pkg::DATA_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_tx_pending = st.tx_pending;
	assign o_tx_word = st.tx_word;
	assign o_ctrl_pri = st.ctrl_pri;
	assign o_ctrl_sec = st.ctrl_sec;
	assign o_baud_divider = st.baud;
	assign o_rx_irq = st.rx_irq;
endmodule

// [uart_regs_checker.sv]
`timescale 1ns/1ps
module uart_regs_checker (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Bus
	input wire logic [2:0] i_sel,
	input wire logic i_wr,
	input wire logic [7:0] o_rdata,
	// Engines and control
	input wire logic i_rx_busy,
	input wire logic i_rx_done,
	input wire logic i_tx_busy,
	input wire logic i_tx_load,
	input wire logic o_tx_pending,
	input wire logic [7:0] o_ctrl_pri,
	input wire logic [7:0] o_ctrl_sec,
	input wire logic o_rx_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	logic st;
	logic dw;
	logic rx_on;
	logic tx_on;
	assign st = i_sel == uart_regs_pkg::SEL_STATUS;
	assign dw = i_wr && i_sel == uart_regs_pkg::SEL_DATA;
	assign rx_on = o_ctrl_pri[7] && o_ctrl_sec[6];
	assign tx_on = o_ctrl_pri[7] && o_ctrl_sec[7];
	// Two busy samples so a registered flag has settled
	rx_idle_low_a: assert property ($past(st) && $past(i_rx_busy) &&
		$past(i_rx_busy, 2) && $past(rx_on, 2) |-> !o_rdata[3])
		else $error("receiver idle set while receiving");
	tx_idle_busy_a: assert property ($past(st) && $past(i_tx_busy) &&
		$past(i_tx_busy, 2) && $past(tx_on, 2) |-> !o_rdata[1])
		else $error("transmitter idle set while sending");
	tx_idle_queued_a: assert property ($past(st) &&
		$past(o_tx_pending, 2) && $past(o_tx_pending) && $past(tx_on)
		|-> !o_rdata[1])
		else $error("transmitter idle set while queued");
	pending_cause_a: assert property ($rose(o_tx_pending) |-> $past(dw))
		else $error("queued word without data write");
	pending_clear_a: assert property (i_tx_load && !dw |=> !o_tx_pending)
		else $error("queued word kept after shifter load");
	irq_cause_a: assert property (o_rx_irq |->
		$past(i_rx_done) && $past(o_ctrl_sec[2]))
		else $error("receive interrupt without enabled transfer");
	irq_pulse_a: assert property (o_rx_irq |=> !o_rx_irq)
		else $error("receive interrupt longer than one cycle");
	disabled_a: assert property ($past(st) && !$past(o_ctrl_pri[7]) &&
		!$past(o_ctrl_pri[7], 2) && !$past(i_sys_rst)
		|-> o_rdata == uart_regs_pkg::STATUS_RESET)
		else $error("status not at rest while port disabled");
endmodule
bind uart_status_and_data_registers uart_regs_checker i_chk (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sel(i_sel), .i_wr(i_wr),
	.o_rdata(o_rdata), .i_rx_busy(i_rx_busy), .i_rx_done(i_rx_done),
	.i_tx_busy(i_tx_busy), .i_tx_load(i_tx_load),
	.o_tx_pending(o_tx_pending), .o_ctrl_pri(o_ctrl_pri),
	.o_ctrl_sec(o_ctrl_sec), .o_rx_irq(o_rx_irq));

// [serial_far_end.sv]
`timescale 1ns/1ps
module serial_far_end #(
	parameter int FRAME = 6
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Bench commands
	input wire logic i_send,
	input wire logic [8:0] i_word,
	input wire logic [2:0] i_err,
	input wire logic i_stall,
	// Engine side
	input wire logic i_tx_pending,
	output logic o_rx_busy,
	output logic o_rx_done,
	output logic [8:0] o_rx_word,
	output logic [2:0] o_rx_err,
	output logic o_tx_busy,
	output logic o_tx_load
);
	int rx_n;
	int tx_n;
	logic [8:0] word_q;
	logic [2:0] err_q;
	assign o_rx_busy = rx_n > 0;
	assign o_tx_busy = tx_n > 0;
	always_ff @(posedge i_clock) begin
		// Word lines churn outside the done pulse, never stale
		o_rx_word <= ~o_rx_word;
		o_rx_err <= ~o_rx_err;
		o_rx_done <= 1'b0;
		o_tx_load <= 1'b0;
		if (i_sys_rst) begin
			rx_n <= 0;
			tx_n <= 0;
			o_rx_word <= 9'h000;
			o_rx_err <= 3'h0;
		end else begin
			if (i_send) begin
				rx_n <= FRAME;
				word_q <= i_word;
				err_q <= i_err;
			end else if (rx_n > 0)
				rx_n <= rx_n - 1;
			if (rx_n == 1) begin
				o_rx_done <= 1'b1;
				o_rx_word <= word_q;
				o_rx_err <= err_q;
			end
			if (tx_n > 0)
				tx_n <= tx_n - 1;
			else if (i_tx_pending && !i_stall) begin
				o_tx_load <= 1'b1;
				tx_n <= FRAME;
			end
		end
	end
endmodule

// [uart_status_and_data_registers_tb.sv]
`timescale 1ns/1ps
module uart_status_and_data_registers_tb;
	localparam logic [2:0] ST = uart_regs_pkg::SEL_STATUS;
	localparam logic [2:0] DT = uart_regs_pkg::SEL_DATA;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] sel = 3'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic send = 1'b0;
	logic stall = 1'b0;
	logic [8:0] s_word = 9'h000;
	logic [2:0] s_err = 3'h0;
	logic [7:0] rdata, q;
	logic [7:0] ctrl_pri, ctrl_sec, baud;
	logic [8:0] rx_word, tx_word;
	logic [2:0] rx_err;
	logic rx_busy, rx_done, tx_busy, tx_load, tx_pending, rx_irq;
	int bad_count = 0;
	int n_checks = 0;
	int irq_n = 0;
	initial forever #2 clock = ~clock;
	always @(posedge clock) if (rx_irq === 1'b1) irq_n++;
	uart_status_and_data_registers i_dut (
		.i_clock(clock), .i_sys_rst(sys_rst), .i_sel(sel), .i_rd(rd),
		.i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .i_rx_busy(rx_busy),
		.i_rx_done(rx_done), .i_rx_word(rx_word),
		.i_rx_parity_bad(rx_err[2]), .i_rx_noise(rx_err[1]),
		.i_rx_frame_bad(rx_err[0]), .i_tx_busy(tx_busy), .i_tx_load(tx_load),
		.o_tx_pending(tx_pending), .o_tx_word(tx_word),
		.o_ctrl_pri(ctrl_pri), .o_ctrl_sec(ctrl_sec),
		.o_baud_divider(baud), .o_rx_irq(rx_irq));
	serial_far_end i_far (
		.i_clock(clock), .i_sys_rst(sys_rst), .i_send(send), .i_word(s_word),
		.i_err(s_err), .i_stall(stall), .i_tx_pending(tx_pending),
		.o_rx_busy(rx_busy), .o_rx_done(rx_done), .o_rx_word(rx_word),
		.o_rx_err(rx_err), .o_tx_busy(tx_busy), .o_tx_load(tx_load));
	task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic bus(input logic [2:0] s, logic w, logic [7:0] d);
		sel = s;
		rd = !w;
		wr = w;
		wdata = d;
		tick(1);
		q = rdata;
		rd = 1'b0;
		wr = 1'b0;
		// Let an edge pass so back-to-back strobes never merge
		tick(1);
	endtask
	task automatic st_is(input logic [7:0] e);
		bus(ST, 1'b0, 8'h00);
		chk("status", e, q);
	endtask
	task automatic dt_is(input logic [7:0] e);
		bus(DT, 1'b0, 8'h00);
		chk("data", e, q);
	endtask
	task automatic rx(input logic [8:0] w, logic [2:0] e);
		s_word = w;
		s_err = e;
		send = 1'b1;
		tick(1);
		send = 1'b0;
	endtask
	task automatic idle;
		for (int k = 0; k < 40 && (rx_busy || tx_busy); k++) tick(1);
		tick(1);
	endtask
	task automatic t_rx;
		bus(3'h1, 1'b1, 8'ha0);
		bus(3'h2, 1'b1, 8'hc4);
		rx(9'h05a, 3'h0);
		tick(2);
		st_is(8'h03);
		idle;
		st_is(8'h0f);
		chk("irq", 8'h01, 8'(irq_n));
		dt_is(8'h5a);
		st_is(8'h0b);
	endtask
	task automatic t_err;
		rx(9'h0a5, 3'h7);
		idle;
		st_is(8'hef);
		dt_is(8'ha5);
		st_is(8'h0b);
		bus(3'h1, 1'b1, 8'h80);
		rx(9'h011, 3'h4);
		idle;
		st_is(8'h0f);
		dt_is(8'h11);
	endtask
	task automatic t_regs;
		rx(9'h1e7, 3'h0);
		idle;
		st_is(8'h0f);
		bus(3'h1, 1'b0, 8'h00);
		chk("ctrl pri", 8'h82, q);
		chk("ctrl pri out", 8'h82, ctrl_pri);
		dt_is(8'he7);
		st_is(8'h0b);
	endtask
	task automatic t_ovr;
		for (int i = 0; i < 4; i++) begin
			rx(9'h0c0 + 9'(i), {1'b0, i == 2, 1'b0});
			idle;
		end
		st_is(8'h1f);
		dt_is(8'hc0);
		st_is(8'h0f);
		dt_is(8'hc1);
		st_is(8'h0b);
	endtask
	task automatic t_tx;
		stall = 1'b1;
		st_is(8'h0b);
		bus(DT, 1'b1, 8'h3c);
		chk("tx word", 8'h3c, tx_word[7:0]);
		chk("tx bit8", 8'h00, 8'(tx_word[8]));
		st_is(8'h08);
		stall = 1'b0;
		tick(3);
		st_is(8'h09);
		idle;
		st_is(8'h0b);
	endtask
	task automatic t_off;
		bus(3'h4, 1'b1, 8'h5c);
		rx(9'h022, 3'h1);
		idle;
		st_is(8'h2f);
		bus(3'h1, 1'b1, 8'h00);
		tick(2);
		st_is(8'h0b);
		bus(3'h4, 1'b0, 8'h00);
		chk("baud", 8'h5c, q);
		chk("baud out", 8'h5c, baud);
		chk("ctrl sec", 8'h04, ctrl_sec);
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		tick(3);
		sys_rst = 1'b0;
		st_is(8'h0b);
		bus(ST, 1'b1, 8'hf4);
		st_is(8'h0b);
		t_rx;
		t_err;
		t_regs;
		t_ovr;
		t_tx;
		t_off;
		wrap_up;
	end
	initial begin
		#4000;
		bad_count++;
		wrap_up;
	end
endmodule
